// file: hdl/exec_pkg.sv
package exec_pkg;

  // Operations handed to the executor, already decoded
  typedef enum logic [4:0] {
    nop_op,
    bit_copy_to_flag_op,
    flag_to_reg_bit_op,
    flag_set_op,
    flag_clear_op,
    carry_set_op,
    carry_clear_op,
    global_irq_enable_op,
    global_irq_disable_op,
    pointer_read_op,
    displaced_pointer_read_op,
    direct_memory_read_op,
    pointer_write_op,
    displaced_pointer_write_op,
    direct_memory_write_op,
    program_memory_read_op,
    stack_push_op,
    stack_pop_op,
    sleep_op,
    watchdog_restart_op,
    break_op
  } op_t;

  // Pointer register choice
  typedef enum logic [1:0] {
    ptr_x,
    ptr_y,
    ptr_z
  } ptr_sel_t;

  // Pointer addressing forms
  typedef enum logic [1:0] {
    ptr_plain,
    ptr_post_inc,
    ptr_pre_dec
  } ptr_mode_t;

  // Execution phases
  typedef enum logic [1:0] {
    ph_idle,
    ph_data,
    ph_prog1,
    ph_prog2
  } phase_t;

  // Flag positions inside flag_register
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // Low register of each pointer pair, and the implied target
  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;
  localparam logic [4:0] REG_R0 = 5'h00;

  // Reset values
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] SP_RESET = 16'hffff;

endpackage

// file: hdl/pointer_address_unit.sv
`timescale 1ns/1ps
module pointer_address_unit
  import exec_pkg::*;
(
  // Pointer and addressing form
  input wire logic [15:0] ptr,
  input wire exec_pkg::ptr_mode_t mode,
  input wire logic displaced,
  input wire logic [5:0] disp,
  // Results
  output logic [15:0] addr,
  output logic [15:0] new_ptr,
  output logic writeback
);

  // Effective address and updated pointer, wrapping at 16 bits
  always_comb begin
    addr = ptr;
    new_ptr = ptr;
    writeback = 1'b0;
    if (displaced) begin
      // Base plus offset, pointer untouched
      addr = ptr + {10'h000, disp};
    end else begin
      unique case (mode)
        ptr_plain: begin
          addr = ptr;
        end
        ptr_post_inc: begin
          // Use then step up
          new_ptr = ptr + 16'h0001;
          writeback = 1'b1;
        end
        ptr_pre_dec: begin
          // Step down then use
          new_ptr = ptr - 16'h0001;
          addr = ptr - 16'h0001;
          writeback = 1'b1;
        end
        default: begin
          addr = ptr;
        end
      endcase
    end
  end

endmodule

// file: hdl/status_flag_unit.sv
`timescale 1ns/1ps
module status_flag_unit
  import exec_pkg::*;
(
  // Current flags and operation
  input wire logic [7:0] flags,
  input wire exec_pkg::op_t op,
  input wire logic [2:0] flag_sel,
  input wire logic src_bit,
  // Updated flags
  output logic [7:0] next_flags
);

  // Touch exactly one flag, or none
  always_comb begin
    next_flags = flags;
    unique case (op)
      bit_copy_to_flag_op: next_flags[FLAG_T] = src_bit;
      flag_set_op: next_flags[flag_sel] = 1'b1;
      flag_clear_op: next_flags[flag_sel] = 1'b0;
      carry_set_op: next_flags[FLAG_C] = 1'b1;
      carry_clear_op: next_flags[FLAG_C] = 1'b0;
      global_irq_enable_op: next_flags[FLAG_I] = 1'b1;
      global_irq_disable_op: next_flags[FLAG_I] = 1'b0;
      default: next_flags = flags;
    endcase
  end

endmodule

// file: hdl/flag_and_data_transfer_exec.sv
// Contract
// - Bit copy sets T flag, one cycle
// - T flag into register bit, one cycle
// - Each flag op changes one flag, one cycle
// - Pointer read two cycles, optional post-increment
// - Pre-decrement pointer, then read, two cycles
// - Read at Y/Z plus offset, pointer kept
// - Direct address read, two cycles, no flags
// - Pointer write two cycles, optional post-increment
// - Pre-decrement pointer, then write, two cycles
// - Write at Y/Z plus offset, pointer kept
// - Direct address write, two cycles, no flags
// - Program read via Z, three cycles, R0 default
// - Stack push two cycles, no flags
// - Stack pop two cycles, no flags
// - Sleep one cycle, no flags
// - Watchdog restart one cycle, pulses restart
// - Break only signals debug, no flags
`timescale 1ns/1ps
module flag_and_data_transfer_exec
  import exec_pkg::*;
#(
  parameter logic [15:0] SP_INIT = SP_RESET
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Decoded operation
  input wire logic op_valid,
  input wire exec_pkg::op_t op,
  input wire logic [4:0] op_dest,
  input wire logic [4:0] op_src,
  input wire logic [2:0] op_bit,
  input wire exec_pkg::ptr_sel_t op_ptr,
  input wire exec_pkg::ptr_mode_t op_mode,
  input wire logic [5:0] op_disp,
  input wire logic [15:0] op_addr,
  input wire logic op_implied,
  output logic busy,
  output logic done,
  // Register file side load while idle, peek at any time
  input wire logic rf_load,
  input wire logic [4:0] rf_load_addr,
  input wire logic [7:0] rf_load_data,
  input wire logic [4:0] rf_peek_addr,
  output logic [7:0] rf_peek_data,
  output logic [7:0] flag_register,
  output logic [15:0] stack_pointer,
  // Data memory and stack
  output logic [15:0] dm_addr,
  output logic [7:0] dm_wdata,
  output logic dm_we,
  output logic dm_re,
  input wire logic [7:0] dm_rdata,
  // Program memory
  output logic [15:0] pm_addr,
  output logic pm_re,
  input wire logic [7:0] pm_rdata,
  // Control strobes
  output logic sleep_req,
  output logic wdt_restart,
  output logic break_req
);

  // Low register index of a pointer pair
  function automatic logic [4:0] ptr_lo(input ptr_sel_t sel);
    unique case (sel)
      ptr_x: ptr_lo = PTR_X_LO;
      ptr_y: ptr_lo = PTR_Y_LO;
      ptr_z: ptr_lo = PTR_Z_LO;
      default: ptr_lo = PTR_Z_LO;
    endcase
  endfunction

  // Reset synchroniser
  logic rst_meta, rst_n;
  // Architectural state
  logic [7:0] regs [32];
  logic [7:0] next_regs [32];
  logic [7:0] next_flag_register;
  logic [15:0] next_stack_pointer;
  // Sequencing state
  phase_t phase, next_phase;
  logic [4:0] pend_dest; // Register awaiting read data
  logic [4:0] next_pend_dest;
  logic pend_load; // Data phase ends with a register load
  logic next_pend_load;
  // Registered outputs
  logic next_busy, next_done, next_sleep_req, next_wdt_restart;
  logic next_break_req, next_dm_we, next_dm_re, next_pm_re;
  logic [7:0] next_rf_peek_data, next_dm_wdata;
  logic [15:0] next_dm_addr, next_pm_addr;
  // Helper results
  logic [4:0] lo_idx; // Selected pointer low register
  logic [15:0] ptr_val; // Selected pointer value
  logic [15:0] z_val; // Z pointer value
  logic use_disp; // Displaced addressing form
  logic disp_ok; // Displacement only through Y or Z
  logic [15:0] agu_addr, agu_ptr, pgu_addr, pgu_ptr; // Address results
  logic agu_wb, pgu_wb; // Pointer write-back requests
  logic [7:0] fu_flags; // Flag unit result

  // Release reset through two flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end
  // Pointer selection
  assign lo_idx = ptr_lo(op_ptr);
  assign ptr_val = {regs[lo_idx + 5'h01], regs[lo_idx]};
  assign z_val = {regs[PTR_Z_LO + 5'h01], regs[PTR_Z_LO]};
  assign use_disp = (op == displaced_pointer_read_op) ||
                    (op == displaced_pointer_write_op);
  assign disp_ok = (op_ptr != ptr_x);
  // Data memory address generation
  pointer_address_unit data_agu (
    .ptr(ptr_val),
    .mode(op_mode),
    .displaced(use_disp),
    .disp(op_disp),
    .addr(agu_addr),
    .new_ptr(agu_ptr),
    .writeback(agu_wb)
  );
  // Program memory address generation, Z only
  pointer_address_unit prog_agu (
    .ptr(z_val),
    .mode((op_mode == ptr_post_inc) ? ptr_post_inc : ptr_plain),
    .displaced(1'b0),
    .disp(6'h00),
    .addr(pgu_addr),
    .new_ptr(pgu_ptr),
    .writeback(pgu_wb)
  );
  // Single flag updates
  status_flag_unit flag_fu (
    .flags(flag_register),
    .op(op),
    .flag_sel(op_bit),
    .src_bit(regs[op_src][op_bit]),
    .next_flags(fu_flags)
  );
  // Next state of the whole executor
  always_comb begin
    next_regs = regs;
    next_flag_register = flag_register;
    next_stack_pointer = stack_pointer;
    next_phase = phase;
    next_pend_dest = pend_dest;
    next_pend_load = pend_load;
    next_done = 1'b0;
    next_rf_peek_data = regs[rf_peek_addr];
    next_dm_addr = dm_addr;
    next_dm_wdata = dm_wdata;
    next_dm_we = 1'b0;
    next_dm_re = 1'b0;
    next_pm_addr = pm_addr;
    next_pm_re = 1'b0;
    next_sleep_req = 1'b0;
    next_wdt_restart = 1'b0;
    next_break_req = 1'b0;
    unique case (phase)
      ph_idle: begin
        if (op_valid) begin
          next_done = 1'b1; // One-cycle ops finish here
          unique case (op)
            bit_copy_to_flag_op: begin
              next_flag_register = fu_flags;
            end
            flag_to_reg_bit_op: begin
              // Flags untouched
              next_regs[op_dest][op_bit] = flag_register[FLAG_T];
            end
            flag_set_op, flag_clear_op, carry_set_op, carry_clear_op,
            global_irq_enable_op, global_irq_disable_op: begin
              next_flag_register = fu_flags;
            end
            pointer_read_op, displaced_pointer_read_op: begin
              if (!use_disp || disp_ok) begin
                // Read at pointer form address
                next_dm_addr = agu_addr;
                next_dm_re = 1'b1;
                next_pend_load = 1'b1;
                next_pend_dest = op_dest;
                next_phase = ph_data;
                next_done = 1'b0;
              end
            end
            direct_memory_read_op: begin
              next_dm_addr = op_addr;
              next_dm_re = 1'b1;
              next_pend_load = 1'b1;
              next_pend_dest = op_dest;
              next_phase = ph_data;
              next_done = 1'b0;
            end
            pointer_write_op, displaced_pointer_write_op: begin
              if (!use_disp || disp_ok) begin
                // Write at pointer form address
                next_dm_addr = agu_addr;
                next_dm_wdata = regs[op_src];
                next_dm_we = 1'b1;
                next_pend_load = 1'b0;
                next_phase = ph_data;
                next_done = 1'b0;
              end
            end
            direct_memory_write_op: begin
              next_dm_addr = op_addr;
              next_dm_wdata = regs[op_src];
              next_dm_we = 1'b1;
              next_pend_load = 1'b0;
              next_phase = ph_data;
              next_done = 1'b0;
            end
            program_memory_read_op: begin
              // Z addressed, R0 when implied
              next_pm_addr = pgu_addr;
              next_pm_re = 1'b1;
              next_pend_dest = op_implied ? REG_R0 : op_dest;
              next_phase = ph_prog1;
              next_done = 1'b0;
              if (pgu_wb && !op_implied) begin
                next_regs[PTR_Z_LO] = pgu_ptr[7:0];
                next_regs[PTR_Z_LO + 5'h01] = pgu_ptr[15:8];
              end
            end
            stack_push_op: begin
              // Store then step down
              next_dm_addr = stack_pointer;
              next_dm_wdata = regs[op_src];
              next_dm_we = 1'b1;
              next_stack_pointer = stack_pointer - 16'h0001;
              next_pend_load = 1'b0;
              next_phase = ph_data;
              next_done = 1'b0;
            end
            stack_pop_op: begin
              // Step up then read
              next_dm_addr = stack_pointer + 16'h0001;
              next_dm_re = 1'b1;
              next_stack_pointer = stack_pointer + 16'h0001;
              next_pend_load = 1'b1;
              next_pend_dest = op_dest;
              next_phase = ph_data;
              next_done = 1'b0;
            end
            sleep_op: next_sleep_req = 1'b1;
            watchdog_restart_op: next_wdt_restart = 1'b1;
            break_op: next_break_req = 1'b1;
            default: next_done = 1'b1; // No-op
          endcase
          // Pointer write-back for data forms
          if ((op == pointer_read_op || op == pointer_write_op) &&
              agu_wb) begin
            next_regs[lo_idx] = agu_ptr[7:0];
            next_regs[lo_idx + 5'h01] = agu_ptr[15:8];
          end
        end else if (rf_load) begin
          // Side load only while idle
          next_regs[rf_load_addr] = rf_load_data;
        end
      end
      ph_data: begin
        // Second cycle of data memory access
        if (pend_load) begin
          next_regs[pend_dest] = dm_rdata;
        end
        next_done = 1'b1;
        next_phase = ph_idle;
      end
      ph_prog1: begin
        // Program memory read latency
        next_pm_re = 1'b1;
        next_phase = ph_prog2;
      end
      ph_prog2: begin
        next_regs[pend_dest] = pm_rdata;
        next_done = 1'b1;
        next_phase = ph_idle;
      end
    endcase
    next_busy = (next_phase != ph_idle);
  end

  // Register all state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      regs <= '{default: REG_RESET};
      flag_register <= FLAGS_RESET;
      stack_pointer <= SP_INIT;
      phase <= ph_idle;
      pend_dest <= 5'h00;
      pend_load <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      rf_peek_data <= REG_RESET;
      dm_addr <= 16'h0000;
      dm_wdata <= 8'h00;
      dm_we <= 1'b0;
      dm_re <= 1'b0;
      pm_addr <= 16'h0000;
      pm_re <= 1'b0;
      sleep_req <= 1'b0;
      wdt_restart <= 1'b0;
      break_req <= 1'b0;
    end else begin
      regs <= next_regs;
      flag_register <= next_flag_register;
      stack_pointer <= next_stack_pointer;
      phase <= next_phase;
      pend_dest <= next_pend_dest;
      pend_load <= next_pend_load;
      busy <= next_busy;
      done <= next_done;
      rf_peek_data <= next_rf_peek_data;
      dm_addr <= next_dm_addr;
      dm_wdata <= next_dm_wdata;
      dm_we <= next_dm_we;
      dm_re <= next_dm_re;
      pm_addr <= next_pm_addr;
      pm_re <= next_pm_re;
      sleep_req <= next_sleep_req;
      wdt_restart <= next_wdt_restart;
      break_req <= next_break_req;
    end
  end

endmodule

// file: dv/mem_model.sv
`timescale 1ns/1ps
module mem_model (
  // Clock
  input wire logic clk_sys,
  // Data memory and stack
  input wire logic [15:0] dm_addr,
  input wire logic [7:0] dm_wdata,
  input wire logic dm_we,
  input wire logic dm_re,
  output logic [7:0] dm_rdata,
  // Program memory
  input wire logic [15:0] pm_addr,
  input wire logic pm_re,
  output logic [7:0] pm_rdata
);
  // Bytes kept by low address byte
  logic [7:0] mem [256] = '{default: 8'h00};
  // Last byte read, inverted on an idle bus
  logic [7:0] held = 8'h00;
  // Write on the strobe, remember reads
  always @(posedge clk_sys) begin
    if (dm_we)
      mem[dm_addr[7:0]] <= dm_wdata;
    if (dm_re)
      held <= dm_rdata;
  end
  // Idle bus never repeats the last value
  assign dm_rdata = dm_re ? mem[dm_addr[7:0]] : ~held;
  // Program bytes follow the address
  assign pm_rdata = pm_re ? pm_addr[7:0] ^ 8'h5a : ~pm_addr[7:0];
endmodule

// file: dv/flag_and_data_transfer_exec_checker.sv
`timescale 1ns/1ps
module flag_and_data_transfer_exec_checker
  import exec_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Operation port
  input wire logic op_valid,
  input wire exec_pkg::op_t op,
  input wire logic [2:0] op_bit,
  input wire logic busy,
  input wire logic done,
  // State and strobes
  input wire logic [7:0] flag_register,
  input wire logic [15:0] stack_pointer,
  input wire logic [15:0] dm_addr,
  input wire logic dm_we,
  input wire logic dm_re,
  input wire logic pm_re,
  input wire logic wdt_restart
);
  // Request taken at this edge
  wire logic tk;
  assign tk = op_valid & ~busy;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_flag_set_one: assert property (
    tk && op == flag_set_op |=> done &&
    flag_register == ($past(flag_register) | (8'h01 << $past(op_bit))))
    else $error("flag set changed the wrong bits");
  a_flag_clear_one: assert property (
    tk && op == flag_clear_op |=> done && flag_register ==
    ($past(flag_register) & ~(8'h01 << $past(op_bit))))
    else $error("flag clear changed the wrong bits");
  a_bit_copy_t: assert property (
    tk && op == bit_copy_to_flag_op |=> done &&
    (flag_register ^ $past(flag_register)) inside {8'h00, 8'h40})
    else $error("bit copy touched a flag other than transfer");
  a_ctrl_no_flags: assert property (
    tk && op inside {flag_to_reg_bit_op, sleep_op, break_op} |=>
    done && $stable(flag_register))
    else $error("control op altered flags or timing");
  a_wdt_pulse_one: assert property (
    tk && op == watchdog_restart_op |=>
    wdt_restart && done ##1 !wdt_restart)
    else $error("watchdog restart pulse wrong");
  a_data_two_cycles: assert property (
    tk && op inside {pointer_read_op, pointer_write_op,
    direct_memory_read_op, direct_memory_write_op} |=>
    busy && (dm_re ^ dm_we) && $stable(flag_register) ##1 done && !busy)
    else $error("data access not two cycles");
  a_prog_three: assert property (
    tk && op == program_memory_read_op |=>
    pm_re [*2] ##1 done && !pm_re)
    else $error("program read not three cycles");
  a_push_stack: assert property (
    tk && op == stack_push_op |=> dm_we &&
    dm_addr == $past(stack_pointer) &&
    stack_pointer == $past(stack_pointer) - 16'h1 ##1 done)
    else $error("push address or pointer wrong");
  a_pop_stack: assert property (
    tk && op == stack_pop_op |=> dm_re &&
    stack_pointer == $past(stack_pointer) + 16'h1 &&
    dm_addr == stack_pointer ##1 done)
    else $error("pop address or pointer wrong");
endmodule
bind flag_and_data_transfer_exec flag_and_data_transfer_exec_checker
  i_flag_and_data_transfer_exec_checker (.*);

// file: dv/test_flag_and_data_transfer_exec.sv
`timescale 1ns/1ps
module test_flag_and_data_transfer_exec;
  import exec_pkg::*;
  // Stimulus
  logic clk_sys = 1'b0, resetn = 1'b0, op_valid = 1'b0, op_implied = 1'b0;
  logic rf_load = 1'b0;
  op_t op = nop_op;
  ptr_sel_t op_ptr = ptr_x;
  ptr_mode_t op_mode = ptr_plain;
  logic [4:0] op_dest = 5'h00, op_src = 5'h00;
  logic [4:0] rf_load_addr = 5'h00, rf_peek_addr = 5'h00;
  logic [2:0] op_bit = 3'h0;
  logic [5:0] op_disp = 6'h00;
  logic [15:0] op_addr = 16'h0000;
  logic [7:0] rf_load_data = 8'h00;
  // Design outputs
  logic busy, done, dm_we, dm_re, pm_re, sleep_req, wdt_restart, break_req;
  logic [7:0] rf_peek_data, flag_register, dm_wdata, dm_rdata, pm_rdata;
  logic [15:0] stack_pointer, dm_addr, pm_addr;
  // Reference state
  logic [7:0] r [32];
  logic [7:0] mm [256] = '{default: 8'h00};
  logic [7:0] f = FLAGS_RESET;
  logic [15:0] sp = SP_RESET;
  logic [31:0] seed = 32'h43;
  int mismatches = 0, checked = 0;
  op_t one [7] = '{carry_set_op, carry_clear_op, global_irq_enable_op,
    global_irq_disable_op, sleep_op, watchdog_restart_op, break_op};
  flag_and_data_transfer_exec i_flag_and_data_transfer_exec (.*);
  mem_model i_mem_model (.*);
  // Clock
  always #4 clk_sys = ~clk_sys;
  // Xorshift source
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Verdict
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Register read through the peek port
  task automatic peek(input int i);
    @(posedge clk_sys) rf_peek_addr <= 5'(i);
    @(posedge clk_sys);
    #1;
    chk(rf_peek_data, r[i]);
  endtask
  // Issue one op, time it, update the model, compare all state
  task automatic go(input op_t o, input int n);
    logic [4:0] l;
    logic [15:0] a;
    logic [15:0] pv;
    op_t e;
    int c;
    @(posedge clk_sys) op <= o;
    op_valid <= 1'b1;
    // Fields set just before the call have settled by this edge
    l = op_ptr == ptr_x ? PTR_X_LO : op_ptr == ptr_y ? PTR_Y_LO : PTR_Z_LO;
    pv = {r[l + 5'h1], r[l]};
    a = pv;
    e = o;
    // Displaced forms through X are refused and only finish
    if (op_ptr == ptr_x &&
        o inside {displaced_pointer_read_op, displaced_pointer_write_op})
      e = nop_op;
    @(posedge clk_sys) op_valid <= 1'b0;
    c = 1;
    #1;
    while (done !== 1'b1 && c < 9) begin
      @(posedge clk_sys);
      #1;
      c++;
    end
    // Address and pointer update
    if (o inside {pointer_read_op, pointer_write_op}) begin
      if (op_mode == ptr_pre_dec)
        a = pv - 16'h1;
      pv = op_mode == ptr_plain ? pv : op_mode == ptr_pre_dec ? a : a + 16'h1;
    end
    if (o inside {displaced_pointer_read_op, displaced_pointer_write_op})
      a = pv + 16'(op_disp);
    if (o inside {direct_memory_read_op, direct_memory_write_op})
      a = op_addr;
    if (o == stack_push_op)
      a = sp--;
    if (o == stack_pop_op)
      a = ++sp;
    {r[l + 5'h1], r[l]} = pv;
    case (e)
      bit_copy_to_flag_op: f[FLAG_T] = r[op_src][op_bit];
      flag_to_reg_bit_op: r[op_dest][op_bit] = f[FLAG_T];
      flag_set_op: f[op_bit] = 1'b1;
      flag_clear_op: f[op_bit] = 1'b0;
      carry_set_op, carry_clear_op: f[FLAG_C] = o == carry_set_op;
      global_irq_enable_op, global_irq_disable_op:
        f[FLAG_I] = o == global_irq_enable_op;
      pointer_write_op, displaced_pointer_write_op, direct_memory_write_op,
        stack_push_op: mm[a[7:0]] = r[op_src];
      pointer_read_op, displaced_pointer_read_op, direct_memory_read_op,
        stack_pop_op: r[op_dest] = mm[a[7:0]];
      program_memory_read_op: begin
        a = {r[31], r[30]};
        r[op_implied ? REG_R0 : op_dest] = a[7:0] ^ 8'h5a;
        if (!op_implied && op_mode == ptr_post_inc)
          {r[31], r[30]} = a + 16'h1;
      end
      default: ;
    endcase
    chk(16'(c), 16'(n));
    chk(sleep_req, o == sleep_op);
    chk(wdt_restart, o == watchdog_restart_op);
    chk(break_req, o == break_op);
    chk(flag_register, f);
    chk(stack_pointer, sp);
    for (int i = 0; i < 32; i++)
      peek(i);
    $display("test %s ended", o.name());
  endtask
  // Hang guard
  initial begin
    #400000;
    mismatches++;
    summarize();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // Random registers, X at zero and Z at the top for wrap
    for (int i = 0; i < 32; i++) begin
      r[i] = i inside {26, 27} ? 8'h00 : i > 29 ? 8'hff : rnd();
      @(posedge clk_sys) rf_load <= 1'b1;
      rf_load_addr <= 5'(i);
      rf_load_data <= r[i];
    end
    @(posedge clk_sys) rf_load <= 1'b0;
    for (int b = 0; b < 8; b++) begin
      op_bit <= 3'(b);
      op_src <= 5'h05;
      op_dest <= 5'h06;
      go(flag_set_op, 1);
      go(flag_clear_op, 1);
      go(bit_copy_to_flag_op, 1);
      go(flag_to_reg_bit_op, 1);
    end
    foreach (one[k])
      go(one[k], 1);
    for (int p = 0; p < 3; p++)
      for (int m = 0; m < 3; m++) begin
        op_ptr <= ptr_sel_t'(p);
        op_mode <= ptr_mode_t'(m);
        op_src <= 5'(p * 3 + m);
        op_dest <= 5'(p * 3 + m + 9);
        go(pointer_write_op, 2);
        go(pointer_read_op, 2);
      end
    for (int p = 1; p < 3; p++) begin
      op_ptr <= ptr_sel_t'(p);
      op_disp <= 6'h3f;
      go(displaced_pointer_write_op, 2);
      go(displaced_pointer_read_op, 2);
    end
    op_ptr <= ptr_x;
    go(displaced_pointer_write_op, 1);
    go(displaced_pointer_read_op, 1);
    op_addr <= 16'h1234;
    go(direct_memory_write_op, 2);
    go(direct_memory_read_op, 2);
    op_implied <= 1'b1;
    go(program_memory_read_op, 3);
    op_implied <= 1'b0;
    op_mode <= ptr_post_inc;
    go(program_memory_read_op, 3);
    op_mode <= ptr_plain;
    go(program_memory_read_op, 3);
    op_src <= 5'h03;
    go(stack_push_op, 2);
    op_dest <= 5'h15;
    go(stack_pop_op, 2);
    summarize();
  end
endmodule
